// [logic/periph_irq_enable_flag_bank.sv]
// Peripheral interrupt enable and request flag bank with an APB register port
`include "irq_bank_params.svh"

// Notes on behaviour
// R1: Request flags set on their event regardless of enables or global enable.
// R2: Pin-change summary flag is the read-only OR of all per-pin change flags.
// R3: Software should clear a pending flag before setting its enable bit.
// R4: Timer 0 overflow sets flag 0 bit 5; held until software writes zero.
// R5: External pin event sets flag 0 bit 0; the pin comes from a select field.
// R6: Timer 1 gate going inactive sets flag 1 bit 7; software clears it.
// R7: Timer 1 event sets flag 1 bit 6; held until a software write clears it.
// R8: Oscillator failure sets flag 1 bit 5; software may clear, never set.
// R9: Clock switch sets flag 1 bit 4; software may clear, never set.
// R10: Clock tuning event sets flag 1 bit 3; held until software clears.
// R11: Memory scanner event sets flag 1 bit 2; held until software clears.
// R12: Checksum unit event sets flag 1 bit 1; held until software clears.
// R13: Enable register 5 holds eight read-write enables, reset to zero.
// R14: Enable register 6 bits 2..0 enable zero-cross, ADC threshold, ADC done.
// R15: Enable register 4 bits 1 and 0 enable waveform generator and oscillator.
// R16: Flag register 0 implements bits 5, 4, 0 only; bit 4 is read-only.
// R17: Flag register 1 resets to zero; bits 5 and 4 not settable by software.
// R18: Peripheral sources also need the peripheral gate; register 0 needs global only.
// R19: Core request is high while any flag meets its set enable bit and the enables of R18 that it needs are set.
module periph_irq_enable_flag_bank (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_ZERO_OVF,
  input wire logic [7:0] PIN_CHANGE_PORT_A_FLAGS,
  input wire logic [7:0] PIN_CHANGE_PORT_C_FLAGS,
  input wire logic [3:0] EXT_IRQ_PINS,
  input wire logic TIMER_ONE_GATE_ACTIVE,
  input wire logic TIMER_ONE_EVENT,
  input wire logic OSC_FAIL_EVENT,
  input wire logic CLOCK_SWITCH_EVENT,
  input wire logic CLOCK_TUNING_EVENT,
  input wire logic MEMORY_SCANNER_EVENT,
  input wire logic CHECKSUM_EVENT,
  input wire logic NVM_DONE_EVENT,
  input wire logic [7:0] SRC_REQ_4,
  input wire logic [7:0] SRC_REQ_5,
  input wire logic [2:0] SRC_REQ_6,
  output logic [7:0] ENABLE_OUT_4,
  output logic [7:0] ENABLE_OUT_5,
  output logic [2:0] ENABLE_OUT_6,
  output logic CORE_IRQ_REQ,
  output logic IRQ
);

  irq_bank_pkg::bus_state_t state;
  irq_bank_pkg::bus_state_t next_state;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;

  irq_bank_pkg::byte_reg_t flags0;
  irq_bank_pkg::byte_reg_t flags1;
  irq_bank_pkg::byte_reg_t flags0_view;
  irq_bank_pkg::byte_reg_t set0;
  irq_bank_pkg::byte_reg_t set1;
  irq_bank_pkg::byte_reg_t wdata1;

  irq_bank_pkg::byte_reg_t enable4;
  irq_bank_pkg::byte_reg_t enable5;
  irq_bank_pkg::byte_reg_t enable6;
  irq_bank_pkg::byte_reg_t flag_en0;
  irq_bank_pkg::byte_reg_t flag_en1;
  irq_bank_pkg::byte_reg_t core_ctrl;
  irq_bank_pkg::byte_reg_t ev_mask;
  irq_bank_pkg::byte_reg_t ev_status;
  irq_bank_pkg::byte_reg_t next_enable4;
  irq_bank_pkg::byte_reg_t next_enable5;
  irq_bank_pkg::byte_reg_t next_enable6;
  irq_bank_pkg::byte_reg_t next_flag_en0;
  irq_bank_pkg::byte_reg_t next_flag_en1;
  irq_bank_pkg::byte_reg_t next_core_ctrl;
  irq_bank_pkg::byte_reg_t next_ev_mask;
  irq_bank_pkg::byte_reg_t next_ev_status;
  irq_bank_pkg::byte_reg_t ev_set;

  logic [3:0] ext_sync;
  logic ext_level;
  logic ext_prev;
  logic gate_prev;
  logic summary;
  logic next_ext_prev;
  logic next_gate_prev;
  logic next_summary;

  logic [7:0] idx;
  logic aligned;
  logic hit;
  irq_bank_pkg::byte_reg_t read_byte;
  logic commit;
  logic wr;
  logic bus_err;

  logic req_direct;
  logic req_periph;
  logic next_core_req;
  logic next_irq;

  // External pins come from outside the clock domain
  pin_sync2 u_ext_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_async(EXT_IRQ_PINS),
    .pin_sync(ext_sync)
  );

  // Slave answers one cycle into the access phase, giving one wait state
  always_comb
  begin
    next_state = state;
    case (state)
      irq_bank_pkg::ST_IDLE:
      begin
        if (PSEL && PENABLE)
        begin
          next_state = irq_bank_pkg::ST_ANSWER;
        end
      end
      irq_bank_pkg::ST_ANSWER:
      begin
        next_state = irq_bank_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = irq_bank_pkg::ST_IDLE;
      end
    endcase
    next_pready = (next_state == irq_bank_pkg::ST_ANSWER);
  end

  // Decode: word aligned, index in address bits 9..2, upper bits zero
  always_comb
  begin
    idx = PADDR[9:2];
    aligned = (PADDR[1:0] == 2'b00) && (PADDR[11:10] == 2'b00);
    hit = 1'b0;
    read_byte = `BYTE_RESET;
    case (idx)
      `REQ_FLAGS_0_IDX:
      begin
        hit = 1'b1;
        read_byte = flags0_view;
      end
      `REQ_FLAGS_1_IDX:
      begin
        hit = 1'b1;
        read_byte = flags1;
      end
      `ENABLE_BITS_4_IDX:
      begin
        hit = 1'b1;
        read_byte = enable4;
      end
      `ENABLE_BITS_5_IDX:
      begin
        hit = 1'b1;
        read_byte = enable5;
      end
      `ENABLE_BITS_6_IDX:
      begin
        hit = 1'b1;
        read_byte = enable6;
      end
      `FLAG_ENABLE_0_IDX:
      begin
        hit = 1'b1;
        read_byte = flag_en0;
      end
      `FLAG_ENABLE_1_IDX:
      begin
        hit = 1'b1;
        read_byte = flag_en1;
      end
      `CORE_CONTROL_IDX:
      begin
        hit = 1'b1;
        read_byte = core_ctrl;
      end
      `EVENT_STATUS_IDX:
      begin
        hit = 1'b1;
        read_byte = ev_status;
      end
      `EVENT_MASK_IDX:
      begin
        hit = 1'b1;
        read_byte = ev_mask;
      end
      default:
      begin
        hit = 1'b0;
        read_byte = `BYTE_RESET;
      end
    endcase
    hit = hit && aligned;
    commit = (state == irq_bank_pkg::ST_ANSWER) && PSEL && PENABLE;
    wr = commit && PWRITE && hit;
    bus_err = commit && !hit;
  end

  // Read data is captured as the answer is prepared; error is a pulse with ready
  always_comb
  begin
    next_prdata = PRDATA;
    next_pslverr = 1'b0;
    if (state == irq_bank_pkg::ST_IDLE && PSEL && PENABLE)
    begin
      next_prdata = {24'h000000, hit ? read_byte : `BYTE_RESET};
      next_pslverr = !hit;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state <= irq_bank_pkg::ST_IDLE;
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      state <= next_state;
      PREADY <= next_pready;
      PRDATA <= next_prdata;
      PSLVERR <= next_pslverr;
    end
  end

  // Edge history; a select change can look like one pin edge
  always_comb
  begin
    ext_level = ext_sync[core_ctrl[`EXT_SEL_MSB:`EXT_SEL_LSB]];
    next_ext_prev = ext_level;
    next_gate_prev = TIMER_ONE_GATE_ACTIVE;
    // R2: summary of pin flags
    next_summary = |{PIN_CHANGE_PORT_A_FLAGS, PIN_CHANGE_PORT_C_FLAGS};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      ext_prev <= 1'b0;
      gate_prev <= 1'b0;
      summary <= 1'b0;
    end
    else
    begin
      ext_prev <= next_ext_prev;
      gate_prev <= next_gate_prev;
      summary <= next_summary;
    end
  end

  // Event set vectors; no enable term appears here on purpose
  always_comb
  begin
    // R1: enables ignored
    set0 = `BYTE_RESET;
    set1 = `BYTE_RESET;
    // R4: timer 0 overflow
    set0[`TIMER_ZERO_BIT] = TIMER_ZERO_OVF;
    // R5: selected pin edge
    set0[`EXT_PIN_BIT] = ext_level && !ext_prev;
    // R6: gate falls inactive
    set1[`GATE_FLAG_BIT] = gate_prev && !TIMER_ONE_GATE_ACTIVE;
    // R7: timer 1 event
    set1[`TIMER_ONE_BIT] = TIMER_ONE_EVENT;
    // R8: oscillator failure
    set1[`OSC_FAIL_BIT] = OSC_FAIL_EVENT;
    // R9: clock switch
    set1[`CLOCK_SWITCH_BIT] = CLOCK_SWITCH_EVENT;
    // R10: clock tuning
    set1[`CLOCK_TUNE_BIT] = CLOCK_TUNING_EVENT;
    // R11: memory scanner
    set1[`SCANNER_BIT] = MEMORY_SCANNER_EVENT;
    // R12: checksum unit
    set1[`CHECKSUM_BIT] = CHECKSUM_EVENT;
    set1[`NVM_BIT] = NVM_DONE_EVENT;
    // R8: clear-only write data
    wdata1 = (PWDATA[7:0] & ~`REQ1_CLEAR_ONLY_MASK) |
             (PWDATA[7:0] & flags1 & `REQ1_CLEAR_ONLY_MASK);
    // R16: only three bits visible
    flags0_view = flags0 & `REQ0_IMPL_MASK;
    flags0_view[`PIN_CHANGE_BIT] = summary;
  end

  // R16: writable bits 5 and 0
  sticky_flag_byte u_flags0 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .hw_set(set0),
    .sw_wr(wr && idx == `REQ_FLAGS_0_IDX),
    .sw_mask(`REQ0_WRITE_MASK),
    .sw_data(PWDATA[7:0]),
    .flags(flags0)
  );

  // R17: reset zero, bits 5 and 4 only clearable
  sticky_flag_byte u_flags1 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .hw_set(set1),
    .sw_wr(wr && idx == `REQ_FLAGS_1_IDX),
    .sw_mask(`REQ1_WRITE_MASK),
    .sw_data(wdata1),
    .flags(flags1)
  );

  // Enable, control and mask registers written from the bus
  always_comb
  begin
    next_enable4 = enable4;
    next_enable5 = enable5;
    next_enable6 = enable6;
    next_flag_en0 = flag_en0;
    next_flag_en1 = flag_en1;
    next_core_ctrl = core_ctrl;
    next_ev_mask = ev_mask;
    if (wr)
    begin
      case (idx)
        // R15: waveform and oscillator enables
        `ENABLE_BITS_4_IDX: next_enable4 = PWDATA[7:0];
        // R13: eight enables
        `ENABLE_BITS_5_IDX: next_enable5 = PWDATA[7:0];
        // R14: three low enables
        `ENABLE_BITS_6_IDX: next_enable6 = PWDATA[7:0] & `ENABLE_6_MASK;
        `FLAG_ENABLE_0_IDX: next_flag_en0 = PWDATA[7:0] & `REQ0_IMPL_MASK;
        `FLAG_ENABLE_1_IDX: next_flag_en1 = PWDATA[7:0];
        `CORE_CONTROL_IDX: next_core_ctrl = PWDATA[7:0];
        `EVENT_MASK_IDX: next_ev_mask = PWDATA[7:0] & `EVENT_IMPL_MASK;
        default: next_ev_mask = ev_mask;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      enable4 <= `BYTE_RESET;
      enable5 <= `BYTE_RESET;
      enable6 <= `BYTE_RESET;
      flag_en0 <= `BYTE_RESET;
      flag_en1 <= `BYTE_RESET;
      core_ctrl <= `BYTE_RESET;
      ev_mask <= `BYTE_RESET;
    end
    else
    begin
      enable4 <= next_enable4;
      enable5 <= next_enable5;
      enable6 <= next_enable6;
      flag_en0 <= next_flag_en0;
      flag_en1 <= next_flag_en1;
      core_ctrl <= next_core_ctrl;
      ev_mask <= next_ev_mask;
    end
  end

  // Core request and sticky event status; set wins over write-one-clear
  always_comb
  begin
    // R18: register 0 sources need the global enable only
    req_direct = core_ctrl[`GLOBAL_EN_BIT] && (|(flags0_view & flag_en0));
    // R18: other sources also need the peripheral gate
    req_periph = core_ctrl[`GLOBAL_EN_BIT] && core_ctrl[`PERIPH_GATE_BIT] &&
                 (|(flags1 & flag_en1) || |(SRC_REQ_4 & enable4) ||
                  |(SRC_REQ_5 & enable5) || |(SRC_REQ_6 & enable6[2:0]));
    // R19: any flag with its enable
    next_core_req = req_direct || req_periph;
    ev_set = `BYTE_RESET;
    ev_set[`EV_CORE_REQ_BIT] = next_core_req && !CORE_IRQ_REQ;
    ev_set[`EV_PIN_CHANGE_BIT] = next_summary && !summary;
    ev_set[`EV_BUS_ERROR_BIT] = bus_err;
    next_ev_status = ev_status;
    if (wr && idx == `EVENT_STATUS_IDX)
    begin
      next_ev_status = ev_status & ~PWDATA[7:0];
    end
    next_ev_status = (next_ev_status | ev_set) & `EVENT_IMPL_MASK;
    next_irq = |(next_ev_status & next_ev_mask);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      ev_status <= `BYTE_RESET;
      CORE_IRQ_REQ <= 1'b0;
      IRQ <= 1'b0;
      ENABLE_OUT_4 <= `BYTE_RESET;
      ENABLE_OUT_5 <= `BYTE_RESET;
      ENABLE_OUT_6 <= 3'h0;
    end
    else
    begin
      ev_status <= next_ev_status;
      CORE_IRQ_REQ <= next_core_req;
      IRQ <= next_irq;
      ENABLE_OUT_4 <= next_enable4;
      ENABLE_OUT_5 <= next_enable5;
      ENABLE_OUT_6 <= next_enable6[2:0];
    end
  end

endmodule

// [include/irq_bank_params.svh]
// Register indices, field positions, masks and reset values of the interrupt bank
`ifndef IRQ_BANK_PARAMS_SVH
`define IRQ_BANK_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define REQ_FLAGS_0_IDX 8'h8c
`define REQ_FLAGS_1_IDX 8'h8d
`define ENABLE_BITS_4_IDX 8'h9a
`define ENABLE_BITS_5_IDX 8'h9b
`define ENABLE_BITS_6_IDX 8'h9c
`define FLAG_ENABLE_0_IDX 8'he0
`define FLAG_ENABLE_1_IDX 8'he1
`define CORE_CONTROL_IDX 8'he2
`define EVENT_STATUS_IDX 8'he3
`define EVENT_MASK_IDX 8'he4

// Request flag register 0 fields
`define TIMER_ZERO_BIT 5
`define PIN_CHANGE_BIT 4
`define EXT_PIN_BIT 0
`define REQ0_WRITE_MASK 8'h21
`define REQ0_IMPL_MASK 8'h31

// Request flag register 1 fields
`define GATE_FLAG_BIT 7
`define TIMER_ONE_BIT 6
`define OSC_FAIL_BIT 5
`define CLOCK_SWITCH_BIT 4
`define CLOCK_TUNE_BIT 3
`define SCANNER_BIT 2
`define CHECKSUM_BIT 1
`define NVM_BIT 0
`define REQ1_WRITE_MASK 8'hff
`define REQ1_CLEAR_ONLY_MASK 8'h30

// Enable register 6 and core control fields
`define ENABLE_6_MASK 8'h07
`define GLOBAL_EN_BIT 7
`define PERIPH_GATE_BIT 6
`define EXT_SEL_MSB 1
`define EXT_SEL_LSB 0

// Event status fields
`define EV_CORE_REQ_BIT 0
`define EV_PIN_CHANGE_BIT 1
`define EV_BUS_ERROR_BIT 2
`define EVENT_IMPL_MASK 8'h07

// Reset value shared by every register
`define BYTE_RESET 8'h00

`endif

// [include/irq_bank_pkg.sv]
// Types shared by the interrupt bank modules
package irq_bank_pkg;

  // Bus slave phase
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ANSWER = 2'b01
  } bus_state_t;

  // One register byte
  typedef logic [7:0] byte_reg_t;

endpackage

// [logic/pin_sync2.sv]
// Two-stage synchroniser for a group of asynchronous pins
module pin_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] pin_async,
  output logic [3:0] pin_sync
);

  logic [3:0] stage1;
  logic [3:0] next_stage1;
  logic [3:0] next_sync;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_bit
      // First stage feeds only the second, to let metastability settle
      always_comb
      begin
        next_stage1[i] = pin_async[i];
        next_sync[i] = stage1[i];
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          stage1[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= next_stage1[i];
          pin_sync[i] <= next_sync[i];
        end
      end
    end
  endgenerate

endmodule

// [logic/sticky_flag_byte.sv]
// Eight sticky request flags, set by hardware and written by software
module sticky_flag_byte (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] hw_set,
  input wire logic sw_wr,
  input wire logic [7:0] sw_mask,
  input wire logic [7:0] sw_data,
  output logic [7:0] flags
);

  logic [7:0] next_flags;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      // Hardware set wins over a software clear in the same cycle
      always_comb
      begin
        next_flags[i] = flags[i];
        if (sw_wr && sw_mask[i])
        begin
          next_flags[i] = sw_data[i];
        end
        if (hw_set[i])
        begin
          next_flags[i] = 1'b1;
        end
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          flags[i] <= 1'b0;
        end
        else
        begin
          flags[i] <= next_flags[i];
        end
      end
    end
  endgenerate

endmodule

// [test/irq_bank_sva.sv]
// Concurrent checks on the interrupt bank register port and flag reads
module irq_bank_sva (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_ZERO_OVF,
  input wire logic [7:0] PIN_CHANGE_PORT_A_FLAGS,
  input wire logic [7:0] PIN_CHANGE_PORT_C_FLAGS,
  input wire logic [7:0] ENABLE_OUT_5,
  input wire logic CORE_IRQ_REQ,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  // Helper terms; a read answer shows state from one edge before
  wire logic ans_rd = PREADY && !PWRITE;
  wire logic pin_any = |{PIN_CHANGE_PORT_A_FLAGS, PIN_CHANGE_PORT_C_FLAGS};
  wire logic en5_wr = PREADY && PWRITE && PADDR == 12'h26c;
  // Handshake shape: exactly one wait state, one-cycle answer
  AST_ONE_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no answer one cycle after access");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside an access");
  AST_UPPER_ZERO: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_MISALIGNED: assert property (PSEL && PENABLE && !PREADY && PADDR[1:0] != 2'b00
    |=> PSLVERR) else $error("misaligned access not refused");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  // Enables move only on a completed write to their own register
  AST_EN5_WRITE: assert property (!$stable(ENABLE_OUT_5) |-> $past(en5_wr))
    else $error("enable 5 changed without a write");
  AST_TZ_FLAG: assert property (
    ans_rd && PADDR == 12'h230 && $past(TIMER_ZERO_OVF, 2) |-> PRDATA[5])
    else $error("overflow flag missing on read");
  AST_SUMMARY: assert property (
    ans_rd && PADDR == 12'h230 && $past(pin_any, 1) == $past(pin_any, 3)
    && $past(pin_any, 2) == $past(pin_any, 3) |-> PRDATA[4] == $past(pin_any, 2))
    else $error("summary flag differs from pin flags");
  AST_F0_RESERVED: assert property (
    ans_rd && PADDR == 12'h230 |-> PRDATA[7:6] == 2'b00 && PRDATA[3:1] == 3'b000)
    else $error("unimplemented flag bits read nonzero");
  AST_EN6_RESERVED: assert property (
    ans_rd && PADDR == 12'h270 |-> PRDATA[7:3] == 5'h00)
    else $error("unimplemented enable bits read nonzero");
  // Main scenarios reached
  COV_CORE: cover property (CORE_IRQ_REQ);
  COV_IRQ: cover property (IRQ);
  COV_ERR: cover property (PSLVERR);
endmodule

bind periph_irq_enable_flag_bank irq_bank_sva chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER_ZERO_OVF(TIMER_ZERO_OVF), .PIN_CHANGE_PORT_A_FLAGS(PIN_CHANGE_PORT_A_FLAGS),
  .PIN_CHANGE_PORT_C_FLAGS(PIN_CHANGE_PORT_C_FLAGS), .ENABLE_OUT_5(ENABLE_OUT_5),
  .CORE_IRQ_REQ(CORE_IRQ_REQ), .IRQ(IRQ));

// [test/periph_event_model.sv]
// Behavioural peripheral event sources facing the interrupt bank
module periph_event_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] req,
  output logic [6:0] events = 7'h00,
  output logic gate_active = 1'b1,
  output logic tz_ovf = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // A request cycle becomes one event cycle; held requests stay high
  // gate drops for one cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      events <= 7'h00;
      gate_active <= 1'b1;
      tz_ovf <= 1'b0;
    end
    else
    begin
      events <= req[6:0];
      gate_active <= !req[7];
      tz_ovf <= req[8];
    end
  end
endmodule

// [test/tb.sv]
// Self-checking bench for the peripheral interrupt bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic core_irq_req, irq, gate_active, tz_ovf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] pin_a, pin_c, en4, en5, q, src4, src5;
  logic [6:0] ev;
  logic [2:0] en6, src6;
  logic [3:0] ext_pins;
  logic [8:0] req;
  int fails, tests_run;

  periph_irq_enable_flag_bank dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER_ZERO_OVF(tz_ovf), .PIN_CHANGE_PORT_A_FLAGS(pin_a), .PIN_CHANGE_PORT_C_FLAGS(pin_c),
    .EXT_IRQ_PINS(ext_pins), .TIMER_ONE_GATE_ACTIVE(gate_active), .TIMER_ONE_EVENT(ev[6]),
    .OSC_FAIL_EVENT(ev[5]), .CLOCK_SWITCH_EVENT(ev[4]), .CLOCK_TUNING_EVENT(ev[3]),
    .MEMORY_SCANNER_EVENT(ev[2]), .CHECKSUM_EVENT(ev[1]), .NVM_DONE_EVENT(ev[0]),
    .SRC_REQ_4(src4), .SRC_REQ_5(src5), .SRC_REQ_6(src6), .ENABLE_OUT_4(en4),
    .ENABLE_OUT_5(en5), .ENABLE_OUT_6(en6), .CORE_IRQ_REQ(core_irq_req), .IRQ(irq));

  periph_event_model src (.clk(clk_sys), .rst(sys_rst), .req(req), .events(ev),
    .gate_active(gate_active), .tz_ovf(tz_ovf));

  // Compare helpers count every check
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask

  // One APB transfer; no fixed latency assumed, the wait is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      $display("MISMATCH pready expected 1 seen %b", pready);
      fails++;
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk8($sformatf("read %h", a), e, q);
  endtask

  // Pulse event sources for one cycle, then let flag and request settle
  task automatic fire(input logic [8:0] r);
    @(posedge clk_sys);
    req <= r;
    @(posedge clk_sys);
    req <= 9'h000;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic t_reset;
    logic [11:0] regs [5] = '{12'h230, 12'h234, 12'h268, 12'h26c, 12'h270};
    foreach (regs[i]) rd(regs[i], 8'h00);
  endtask

  // enable bits read back and drive outputs
  task automatic t_enables;
    wr(12'h268, 8'hff);
    wr(12'h26c, 8'hff);
    wr(12'h270, 8'hff);
    rd(12'h268, 8'hff);
    rd(12'h270, 8'h07);
    chk8("enable out 4", 8'hff, en4);
    chk8("enable out 5", 8'hff, en5);
    chk8("enable out 6", 8'h07, {5'h00, en6});
    wr(12'h26c, 8'h5a);
    rd(12'h26c, 8'h5a);
    wr(12'h268, 8'h00);
    wr(12'h26c, 8'h00);
    wr(12'h270, 8'h00);
  endtask

  // each source sets only its flag
  task automatic t_flags1;
    for (int b = 7; b >= 0; b--)
    begin
      fire(9'h001 << b);
      rd(12'h234, 8'h01 << b);
      wr(12'h234, 8'h00);
    end
    rd(12'h234, 8'h00);
    wr(12'h234, 8'hff);
    rd(12'h234, 8'hcf);
    wr(12'h234, 8'h00);
  endtask

  // held overflow, change summary and external pin
  task automatic t_flags0;
    @(posedge clk_sys);
    req <= 9'h100;
    pin_c <= 8'h80;
    repeat (3) @(posedge clk_sys);
    rd(12'h230, 8'h30);
    req <= 9'h000;
    wr(12'h230, 8'h00);
    rd(12'h230, 8'h10);
    wr(12'h230, 8'hff);
    rd(12'h230, 8'h31);
    pin_c <= 8'h00;
    pin_a <= 8'h04;
    wr(12'h230, 8'h00);
    rd(12'h230, 8'h10);
    pin_a <= 8'h00;
    repeat (3) @(posedge clk_sys);
    rd(12'h230, 8'h00);
    wr(12'h388, 8'h02);
    ext_pins <= 4'h4;
    repeat (5) @(posedge clk_sys);
    rd(12'h230, 8'h01);
    ext_pins <= 4'h0;
    wr(12'h230, 8'h00);
    wr(12'h388, 8'h00);
  endtask

  // stale flags cleared first, then gating of the core request
  task automatic t_core;
    wr(12'h230, 8'h00);
    wr(12'h234, 8'h00);
    wr(12'h384, 8'h40);
    wr(12'h380, 8'h20);
    wr(12'h388, 8'h80);
    fire(9'h040);
    chk1("core req without gate", 1'b0, core_irq_req);
    fire(9'h100);
    chk1("core req timer zero", 1'b1, core_irq_req);
    wr(12'h230, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk1("core req dropped", 1'b0, core_irq_req);
    wr(12'h388, 8'hc0);
    repeat (2) @(posedge clk_sys);
    chk1("core req with gate", 1'b1, core_irq_req);
    wr(12'h234, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk1("core req cleared", 1'b0, core_irq_req);
    // Requests of sources whose enables live here, each enabled in turn
    src4 <= 8'h02;
    src5 <= 8'h10;
    src6 <= 3'h4;
    wr(12'h268, 8'h02);
    repeat (2) @(posedge clk_sys);
    chk1("core req source 4", 1'b1, core_irq_req);
    wr(12'h268, 8'h00);
    wr(12'h26c, 8'h10);
    repeat (2) @(posedge clk_sys);
    chk1("core req source 5", 1'b1, core_irq_req);
    wr(12'h26c, 8'h00);
    wr(12'h270, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk1("core req source 6", 1'b1, core_irq_req);
    wr(12'h388, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk1("core req source 6 no gate", 1'b0, core_irq_req);
    wr(12'h270, 8'h00);
    {src4, src5, src6} <= 19'h00000;
    wr(12'h388, 8'h00);
  endtask

  // Bus errors raise the event interrupt only while unmasked
  task automatic t_errors;
    wr(12'h38c, 8'h07);
    wr(12'h390, 8'h04);
    rd(12'h004, 8'h00);
    chk1("unmapped error", 1'b1, err);
    @(posedge clk_sys);
    chk1("irq raised", 1'b1, irq);
    wr(12'h38c, 8'h04);
    @(posedge clk_sys);
    chk1("irq cleared", 1'b0, irq);
    wr(12'h390, 8'h00);
    rd(12'h231, 8'h00);
    chk1("misaligned error", 1'b1, err);
    @(posedge clk_sys);
    chk1("irq masked", 1'b0, irq);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Main sequence after a long reset
  initial
  begin
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {pin_a, pin_c} = 16'h0000;
    {src4, src5, src6} = 19'h00000;
    ext_pins = 4'h0;
    req = 9'h000;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_enables;
    t_flags1;
    t_flags0;
    t_core;
    t_errors;
    results;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #500000;
    fails++;
    results;
  end
endmodule
